// >>> hdl/glitch_free_mux.sv
/*
 * Glitch-free clock selector for one output pin.
 * Assumes all candidate clocks are sampled levels in the clk_i domain.
 */
`timescale 1ns/1ns
module glitch_free_mux
   import rate_sel_pkg::*;
#(
   parameter int N = 16
) (
   // Clock and reset.
   input  wire logic         clk_i,
   input  wire logic         reset_i,
   // Selection.
   input  wire logic [3:0]   sel_i,
   input  wire logic [N-1:0] src_i,
   // Output.
   output logic              clk_o,
   output logic [3:0]        cur_o
);
   logic [3:0] cur_q;
   logic [3:0] cur_d;
   logic       out_q;
   logic       out_d;

   // The source only changes while both old and new are low, so no
   // shortened high phase reaches the pin; a low phase can still be cut short.
   always_comb begin
      cur_d = cur_q;
      if (sel_i != cur_q && !src_i[cur_q] && !src_i[sel_i]) begin
         cur_d = sel_i;
      end
      out_d = (cur_d == SRC_OFF) ? 1'b0 : src_i[cur_d];
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         cur_q <= 4'h0;
         out_q <= 1'b0;
      end else begin
         cur_q <= cur_d;
         out_q <= out_d;
      end
   end

   assign clk_o = out_q;
   assign cur_o = cur_q;

   AST_SWITCH_LOW: assert property (@(posedge clk_i) disable iff (reset_i)
      (cur_q != $past(cur_q)) |-> !out_q)
      else $error("selector switched while output high");
endmodule

// >>> hdl/output_rate_select_regs.sv
/*
 * Output rate select registers and per-pin clock selection.
 * Assumes PLL and rate clocks arrive as asynchronous levels, far below
 * half the 125 MHz bus clock, and an APB master on clk_i.
 */
`timescale 1ns/1ns
module output_rate_select_regs
   import rate_sel_pkg::*;
(
   // Clock and reset.
   input  wire logic     clk_i,
   input  wire logic     reset_i,
   // Register bus.
   input  wire apb_req_t apb_i,
   output apb_rsp_t      apb_o,
   // Source clocks from outside.
   input  wire logic     rate_2k_i,
   input  wire logic     rate_8k_i,
   input  wire logic     prog_rate_one_i,
   input  wire logic     prog_rate_two_i,
   input  wire logic     primary_path_pll_i,
   input  wire logic     secondary_path_pll_i,
   // Output clocks.
   output logic          out1_clk_o,
   output logic          out3_clk_o,
   output logic          out4_clk_o
);
   // ****************************************************************
   // Input synchronisers
   // ****************************************************************
   logic [5:0] raw;
   logic [5:0] s1_q;
   logic [5:0] s2_q;
   assign raw = {secondary_path_pll_i, primary_path_pll_i, prog_rate_two_i,
                 prog_rate_one_i, rate_8k_i, rate_2k_i};
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         s1_q <= 6'h00;
         s2_q <= 6'h00;
      end else begin
         s1_q <= raw;
         s2_q <= s1_q;
      end
   end

   // ****************************************************************
   // Dividers
   // ****************************************************************
   // Dividers count edges of the live PLL levels, so any PLL retune is
   // followed without reprogramming here.
   logic       p_prev_q;
   logic       s_prev_q;
   logic [5:0] p_cnt_q;
   logic [5:0] p_cnt_d;
   logic [5:0] s_cnt_q;
   logic [5:0] s_cnt_d;
   logic       p_rise;
   logic       s_rise;
   logic [15:0] src;
   logic [7:0] p_div_q;
   logic [7:0] p_div_d;
   logic [2:0] s_div_q;
   logic [2:0] s_div_d;
   logic [6:0] p_cnt_next;
   logic [6:0] s_cnt_next;
   logic [5:0] s48_q;
   logic [5:0] s48_d;
   logic [6:0] s48_next;

   assign p_rise = s2_q[4] & ~p_prev_q;
   assign s_rise = s2_q[5] & ~s_prev_q;

   function automatic logic half_wave(input logic [5:0] cnt, input logic [5:0] n);
      half_wave = (cnt < (n >> 1));
   endfunction

   always_comb begin
      p_cnt_next = {1'b0, p_cnt_q} + 7'h01;
      s_cnt_next = {1'b0, s_cnt_q} + 7'h01;
      s48_next = {1'b0, s48_q} + 7'h01;
      p_cnt_d = p_cnt_q;
      s_cnt_d = s_cnt_q;
      s48_d = s48_q;
      if (p_rise) begin
         p_cnt_d = (p_cnt_q == 6'h2f) ? 6'h00 : p_cnt_next[5:0];
      end
      if (s_rise) begin
         s_cnt_d = (s_cnt_q == 6'h3f) ? 6'h00 : s_cnt_next[5:0];
         s48_d = (s48_q == 6'h2f) ? 6'h00 : s48_next[5:0];
      end
      // Each primary ratio divides 48 evenly. The secondary side keeps its
      // own modulo-48 counter, since 48 does not divide 64.
      p_div_d[0] = half_wave(p_cnt_q, 6'h30);
      p_div_d[1] = half_wave(6'(p_cnt_q % 6'h10), 6'h10);
      p_div_d[2] = half_wave(6'(p_cnt_q % 6'h0c), 6'h0c);
      p_div_d[3] = half_wave(6'(p_cnt_q % 6'h08), 6'h08);
      p_div_d[4] = half_wave(6'(p_cnt_q % 6'h06), 6'h06);
      p_div_d[5] = half_wave(6'(p_cnt_q % 6'h04), 6'h04);
      p_div_d[6] = p_cnt_q[0];
      p_div_d[7] = s2_q[4];
      s_div_d[0] = s_cnt_q[5];
      s_div_d[1] = half_wave(s48_q, 6'h30);
      s_div_d[2] = s_cnt_q[1];
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         p_prev_q <= 1'b0;
         s_prev_q <= 1'b0;
         p_cnt_q  <= 6'h00;
         s_cnt_q  <= 6'h00;
         s48_q    <= 6'h00;
         p_div_q  <= 8'h00;
         s_div_q  <= 3'h0;
      end else begin
         p_prev_q <= s2_q[4];
         s_prev_q <= s2_q[5];
         p_cnt_q  <= p_cnt_d;
         s_cnt_q  <= s_cnt_d;
         s48_q    <= s48_d;
         p_div_q  <= p_div_d;
         s_div_q  <= s_div_d;
      end
   end

   // Source order follows the selector codes of the third output.
   assign src = {s_div_q[2], s_div_q[1], s_div_q[0], p_div_q[7], p_div_q[6],
                 p_div_q[5:0], s2_q[2], s2_q[3], s2_q[1], s2_q[0], 1'b0};

   // ****************************************************************
   // Registers
   // ****************************************************************
   logic [7:0] out3_q;
   logic [7:0] out3_d;
   logic [7:0] out41_q;
   logic [7:0] out41_d;
   apb_rsp_t   rsp_q;
   apb_rsp_t   rsp_d;
   logic       wr_en;
   logic       hit3;
   logic       hit41;

   assign hit3  = apb_i.paddr == OUT3_ADDR;
   assign hit41 = apb_i.paddr == OUT41_ADDR;
   assign wr_en = apb_i.psel & apb_i.penable & apb_i.pwrite;

   always_comb begin
      out3_d  = out3_q;
      out41_d = out41_q;
      rsp_d   = '0;
      if (wr_en && hit3) begin
         out3_d = {4'h0, apb_i.pwdata[OUT3_LSB +: SEL_W]};
      end
      if (wr_en && hit41) begin
         out41_d = apb_i.pwdata[7:0];
      end
      if (apb_i.psel && !apb_i.penable) begin
         rsp_d.pslverr = ~(hit3 | hit41);
         if (hit3) begin
            rsp_d.prdata = {24'h0, out3_q};
         end else if (hit41) begin
            rsp_d.prdata = {24'h0, out41_q};
         end
      end else if (apb_i.psel && apb_i.penable) begin
         rsp_d = rsp_q;
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         out3_q  <= OUT3_RESET;
         out41_q <= OUT41_RESET;
         rsp_q   <= '0;
      end else begin
         out3_q  <= out3_d;
         out41_q <= out41_d;
         rsp_q   <= rsp_d;
      end
   end

   // Zero-wait slave: the access phase always completes in one cycle.
   assign apb_o = '{pready:  1'b1,
                    pslverr: rsp_q.pslverr & apb_i.psel & apb_i.penable,
                    prdata:  rsp_q.prdata};

   // ****************************************************************
   // Per-output code mapping
   // ****************************************************************
   logic [3:0] sel1;
   logic [3:0] sel3;
   logic [3:0] sel4;
   logic [3:0] cur3;

   always_comb begin
      sel3 = out3_q[OUT3_LSB +: SEL_W];
      sel4 = out41_q[OUT4_LSB +: SEL_W];
      sel1 = out41_q[OUT1_LSB +: SEL_W];
      case (sel1)
         4'h3:    sel1 = SRC_P2;
         4'h4:    sel1 = SRC_DIG1;
         4'h5:    sel1 = SRC_P1;
         4'hb:    sel1 = SRC_S64;
         4'hc:    sel1 = SRC_S48;
         default: sel1 = out41_q[OUT1_LSB +: SEL_W];
      endcase
   end

   glitch_free_mux #(.N(NUM_SRC)) u_mux1 (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .sel_i   (sel1),
      .src_i   (src),
      .clk_o   (out1_clk_o),
      .cur_o   ()
   );
   glitch_free_mux #(.N(NUM_SRC)) u_mux3 (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .sel_i   (sel3),
      .src_i   (src),
      .clk_o   (out3_clk_o),
      .cur_o   (cur3)
   );
   glitch_free_mux #(.N(NUM_SRC)) u_mux4 (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .sel_i   (sel4),
      .src_i   (src),
      .clk_o   (out4_clk_o),
      .cur_o   ()
   );

   // ****************************************************************
   // Checks
   // ****************************************************************
   AST_OUT3_WRITE: assert property (@(posedge clk_i) disable iff (reset_i)
      (wr_en && hit3) |=> (out3_q[3:0] == $past(apb_i.pwdata[3:0])))
      else $error("out3 write not stored");
   AST_OUT3_UPPER: assert property (@(posedge clk_i) disable iff (reset_i)
      out3_q[7:4] == 4'h0)
      else $error("out3 upper nibble nonzero");
   AST_OUT3_OFF: assert property (@(posedge clk_i) disable iff (reset_i)
      (cur3 == SRC_OFF) |=> !out3_clk_o)
      else $error("out3 driven while off");
   AST_OUT3_P4: assert property (@(posedge clk_i) disable iff (reset_i)
      (cur3 == SRC_P4) |=> (out3_clk_o == $past(p_div_q[5])))
      else $error("out3 not primary div4");
   AST_OUT1_MAP: assert property (@(posedge clk_i) disable iff (reset_i)
      (out41_q[7:4] == 4'h3) |-> (sel1 == SRC_P2))
      else $error("out1 code 3 not primary div2");
   AST_OUT4_MAP: assert property (@(posedge clk_i) disable iff (reset_i)
      (out41_q[3:0] == 4'h3) |-> (sel4 == SRC_DIG2))
      else $error("out4 code 3 not prog_rate_two");
   AST_PCNT_WRAP: assert property (@(posedge clk_i) disable iff (reset_i)
      (p_rise && p_cnt_q == 6'h2f) |=> (p_cnt_q == 6'h00))
      else $error("primary divider wrap wrong");
   AST_PCNT_HOLD: assert property (@(posedge clk_i) disable iff (reset_i)
      !p_rise |=> $stable(p_cnt_q))
      else $error("primary divider moved without edge");
   AST_S48_WRAP: assert property (@(posedge clk_i) disable iff (reset_i)
      (s_rise && s48_q == 6'h2f) |=> (s48_q == 6'h00))
      else $error("secondary div48 counter wrap wrong");
   COV_WRITE3: cover property (@(posedge clk_i) wr_en && hit3);
   COV_READ41: cover property (@(posedge clk_i) apb_i.psel && !apb_i.pwrite && hit41);
   COV_P48: cover property (@(posedge clk_i) cur3 == SRC_P48 && out3_clk_o);
endmodule

// >>> hdl/rate_sel_pkg.sv
/*
 * Package for the output rate select registers: offsets, reset values,
 * field positions, selector codes and the bus carrier types.
 * Assumes a 32-bit APB register bus, one aligned word per register.
 */
package rate_sel_pkg;
   // Printed offsets are not multiples of four: they are indices.
   localparam logic [7:0]  OUT3_IDX         = 8'h61;
   localparam logic [7:0]  OUT41_IDX        = 8'h62;
   localparam logic [11:0] OUT3_ADDR        = {2'h0, OUT3_IDX, 2'h0};
   localparam logic [11:0] OUT41_ADDR       = {2'h0, OUT41_IDX, 2'h0};
   localparam logic [7:0]  OUT3_RESET       = 8'h02;
   localparam logic [7:0]  OUT41_RESET      = 8'h84;
   localparam int          SEL_W            = 4;
   localparam int          OUT1_LSB         = 4;
   localparam int          OUT4_LSB         = 0;
   localparam int          OUT3_LSB         = 0;
   localparam int          NUM_SRC          = 16;

   // Source indices on the shared source bus.
   localparam logic [3:0] SRC_OFF      = 4'h0;
   localparam logic [3:0] SRC_2K       = 4'h1;
   localparam logic [3:0] SRC_8K       = 4'h2;
   localparam logic [3:0] SRC_DIG2     = 4'h3;
   localparam logic [3:0] SRC_DIG1     = 4'h4;
   localparam logic [3:0] SRC_P48      = 4'h5;
   localparam logic [3:0] SRC_P16      = 4'h6;
   localparam logic [3:0] SRC_P12      = 4'h7;
   localparam logic [3:0] SRC_P8       = 4'h8;
   localparam logic [3:0] SRC_P6       = 4'h9;
   localparam logic [3:0] SRC_P4       = 4'ha;
   localparam logic [3:0] SRC_P2       = 4'hb;
   localparam logic [3:0] SRC_P1       = 4'hc;
   localparam logic [3:0] SRC_S64      = 4'hd;
   localparam logic [3:0] SRC_S48      = 4'he;
   localparam logic [3:0] SRC_S4       = 4'hf;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;

   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } apb_rsp_t;
endpackage

// >>> tb/tb_output_rate_select_regs.sv
/* Testbench for output_rate_select_regs: APB register access and clock
   selection on the three output pins.
   Assumes source clocks made here from clk_i, all far below clk_i/4. */
`timescale 1ns/1ns
module tb_output_rate_select_regs import rate_sel_pkg::*;;
   logic       clk_i      = 1'b0;
   logic       reset_i    = 1'b1;
   apb_req_t   req        = '0;
   apb_rsp_t   rsp;
   logic [5:0] src        = '0;
   logic [2:0] outs;
   int         half [6]   = '{20, 14, 10, 18, 4, 6};
   int         cnt [6]    = '{default: 0};
   int         cyc        = 0;
   int         hi_len     = 0;
   int         err_count  = 0;
   int         num_checks = 0;
   logic [31:0] rd;
   logic        err;

   // ****************
   // Clock and sources
   // ****************
   always #4 clk_i = ~clk_i;

   // Periods in clk_i cycles are all different, so a wrong route shows, except P6 against S4 (both 48).
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      for (int i = 0; i < 6; i++) begin
         if (cnt[i] >= half[i] - 1) begin
            cnt[i] <= 0;
            src[i] <= ~src[i];
         end else begin
            cnt[i] <= cnt[i] + 1;
         end
      end
   end

   output_rate_select_regs i_output_rate_select_regs (
      .clk_i(clk_i), .reset_i(reset_i), .apb_i(req), .apb_o(rsp),
      .rate_2k_i(src[0]), .rate_8k_i(src[1]), .prog_rate_one_i(src[2]),
      .prog_rate_two_i(src[3]), .primary_path_pll_i(src[4]),
      .secondary_path_pll_i(src[5]), .out1_clk_o(outs[0]),
      .out3_clk_o(outs[1]), .out4_clk_o(outs[2]));

   // ****************
   // Helpers
   // ****************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      @(posedge clk_i);
      req <= '{1'b1, 1'b0, wr, a, wd};
      @(posedge clk_i);
      req.penable <= 1'b1;
      do @(posedge clk_i); while (rsp.pready !== 1'b1);
      rd = rsp.prdata;
      err = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask

   task automatic wait_lvl(input int w, input logic v);
      int n;
      n = 0;
      while (outs[w] !== v && n < 3000) begin
         @(posedge clk_i);
         n++;
      end
   endtask

   // Skips a settle time first, since a switch waits for both sources low.
   task automatic meas(input int w, input int exp);
      int t;
      repeat (500) @(posedge clk_i);
      wait_lvl(w, 1'b0);
      wait_lvl(w, 1'b1);
      t = cyc;
      wait_lvl(w, 1'b0);
      wait_lvl(w, 1'b1);
      chk(cyc - t, exp);
   endtask

   task automatic quiet(input int w);
      int ones;
      ones = 0;
      repeat (300) @(posedge clk_i);
      repeat (500) begin
         @(posedge clk_i);
         if (outs[w] !== 1'b0) ones++;
      end
      chk(ones, 0);
   endtask

   // Every legal source holds high for at least four cycles.
   always @(posedge clk_i) begin
      if (outs[1] === 1'b1) hi_len <= hi_len + 1;
      else begin
         if (hi_len == 1 || hi_len == 2) chk(hi_len, 32'h3);
         hi_len <= 0;
      end
   end

   // ****************
   // Tests
   // ****************
   task automatic t_reset;
      xfer(1'b0, OUT3_ADDR, 32'h0);
      chk(rd, 32'h02);
      xfer(1'b0, OUT41_ADDR, 32'h0);
      chk(rd, 32'h84);
      meas(1, 28);
      meas(0, 64);
      meas(2, 20);
      $display("test reset done");
   endtask

   task automatic t_regs;
      xfer(1'b1, OUT3_ADDR, 32'hff);
      xfer(1'b0, OUT3_ADDR, 32'h0);
      chk(rd, 32'h0f);
      chk({31'h0, err}, 32'h0);
      xfer(1'b1, OUT41_ADDR, 32'h5a);
      xfer(1'b0, OUT41_ADDR, 32'h0);
      chk(rd, 32'h5a);
      xfer(1'b1, 12'h190, 32'h33);
      chk({31'h0, err}, 32'h1);
      xfer(1'b0, 12'h190, 32'h0);
      chk({err, rd[30:0]}, 32'h80000000);
      xfer(1'b0, OUT3_ADDR, 32'h0);
      chk(rd, 32'h0f);
      $display("test registers done");
   endtask

   // Codes 13 to 15 pick the secondary PLL (period 12) over 64, 48 and 4.
   task automatic t_out3;
      int codes [13] = '{1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 13, 14, 15};
      int pers [13]  = '{40, 28, 36, 20, 384, 128, 96, 64, 48, 32, 768, 576, 48};
      for (int i = 0; i < 13; i++) begin
         xfer(1'b1, OUT3_ADDR, 32'(codes[i]));
         meas(1, pers[i]);
      end
      xfer(1'b1, OUT3_ADDR, 32'h0);
      quiet(1);
      $display("test out3 done");
   endtask

   task automatic t_out41;
      int vals [3] = '{32'h13, 32'h24, 32'h3a};
      int p1 [3]   = '{40, 28, 16};
      int p4 [3]   = '{36, 20, 32};
      for (int i = 0; i < 3; i++) begin
         xfer(1'b1, OUT41_ADDR, 32'(vals[i]));
         meas(0, p1[i]);
         meas(2, p4[i]);
      end
      xfer(1'b1, OUT41_ADDR, 32'h0);
      quiet(0);
      quiet(2);
      $display("test out1 out4 done");
   endtask

   task automatic t_pll;
      xfer(1'b1, OUT3_ADDR, 32'ha);
      half[4] <= 6;
      meas(1, 48);
      half[4] <= 4;
      meas(1, 32);
      $display("test pll follow done");
   endtask

   // ****************
   // Main
   // ****************
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   initial begin
      repeat (20) @(posedge clk_i);
      reset_i <= 1'b0;
      t_reset;
      t_regs;
      t_out3;
      t_out41;
      t_pll;
      print_verdict;
   end

   // The tests need about 19000 cycles; four times that means a hang.
   initial begin
      repeat (80000) @(posedge clk_i);
      chk(32'h0, 32'h1);
      print_verdict;
   end
endmodule
